/* hdl/clock_unit_defs.svh */
// Offsets, field positions, reset values and timing counts of the
// clock source and output unit. Definitions only; included by name.
`ifndef CLOCK_UNIT_DEFS_SVH
`define CLOCK_UNIT_DEFS_SVH

// ============================================================
// Register offsets
`define OFS_RC_TUNE        8'h96
`define OFS_CORE_DIV       8'hC8
`define OFS_CLOCK_STATUS   8'hC9

// ============================================================
// Field positions
`define TUNE_DIVIDED_CLOCK_OUTPUT_PIN_BIT    6
`define TUNE_TRIM_MSB      5
`define STAT_RUN_BIT       7
`define STAT_DIVIDED_CLOCK_OUTPUT_PIN_BIT    6
`define STAT_AVAIL_BIT     5
`define STAT_SRC_MSB       2

// ============================================================
// Reset values
`define RST_FACTORY_TUNE   7'h20
`define RST_CORE_DIV       8'h00

// ============================================================
// Wake-up timing
`define XTAL_WAKE_OSC      12'd992
`define OTHER_WAKE_OSC     12'd224
`define WAKE_SETTLE_NS     60000
`define REF_CLK_PERIOD_NS  25
`define WAKE_SETTLE_CYCLES \
  ((`WAKE_SETTLE_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

/* hdl/clock_unit_pkg.sv */
// Types of the clock source and output unit.
// Assumes nothing beyond a SystemVerilog compiler.
package clock_unit_pkg;

  // ============================================================
  // Oscillator source, fixed by nonvolatile configuration
  typedef enum logic [2:0] {
    SRC_WATCHDOG  = 3'b000,
    SRC_RC        = 3'b001,
    SRC_XTAL_LOW  = 3'b010,
    SRC_XTAL_MED  = 3'b011,
    SRC_XTAL_HIGH = 3'b100,
    SRC_EXTERNAL  = 3'b101
  } source_t;

  // ============================================================
  // Wake-up sequence
  typedef enum logic [1:0] {
    WAKE_OSC  = 2'b00,
    WAKE_TIME = 2'b01,
    WAKE_RUN  = 2'b10,
    WAKE_STOP = 2'b11
  } wake_t;

  // ============================================================
  // Crystal amplifier range
  typedef enum logic [1:0] {
    RANGE_LOW  = 2'b00,
    RANGE_MED  = 2'b01,
    RANGE_HIGH = 2'b10,
    RANGE_OFF  = 2'b11
  } xtal_range_t;

endpackage

/* hdl/core_clock_divider.sv */
// Core clock divider: turns oscillator ticks into core clock ticks.
// Assumes oscTick is a one-cycle pulse on ref_clk.
module core_clock_divider #(
  parameter int DIV_WIDTH = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic                 oscTick,
  input  wire logic [DIV_WIDTH-1:0] divideValue,
  output logic                      divTick
);

  // ============================================================
  // Parameter check
  if (DIV_WIDTH < 1 || DIV_WIDTH > 8) begin : g_bad_width
    $error("DIV_WIDTH must be 1 to 8");
  end

  // ============================================================
  // Counter
  logic [DIV_WIDTH:0] cnt;
  wire  [DIV_WIDTH:0] limit;
  wire                atLimit;

  // Divide by twice the value, zero means no division
  assign limit   = (divideValue == '0) ? '0 : {divideValue, 1'b0} - 1'b1;
  // Compare, not equality: a new value never strands the counter
  assign atLimit = (cnt >= limit);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt     <= '0;
      divTick <= 1'b0;
    end else begin
      divTick <= oscTick && atLimit;
      if (oscTick) begin
        cnt <= atLimit ? '0 : cnt + 1'b1;
      end
    end
  end

  // ============================================================
  // Assertions
  property p_tick_from_osc;
    @(posedge ref_clk) disable iff (!rst_b)
      divTick |-> $past(oscTick);
  endproperty
  AST_DIV_FROM_OSC: assert property (p_tick_from_osc)
    else $error("core tick without oscillator tick");

endmodule

/* hdl/clock_source_and_output_unit.sv */
// Clock source selection, wake-up delay, core and peripheral clock
// enables, RC trim register and the divided clock output pin.
// Assumes one 40 MHz ref_clk; oscillator and pin inputs are async.
//
// Functional notes
// - Oscillator source is one of six, fixed by nonvolatile config
// - Oscillator clock feeds core divider producing the CPU core clock
// - A machine cycle spans two core clocks
// - Peripheral clock runs at exactly half the core clock
// - Crystal offers low, medium and high ranges
// - RC oscillator runs nominally at 7.373 MHz with factory trim
// - Six-bit writable trim field tunes the RC oscillator
// - Only power-on reset loads factory trim; others keep it
// - Watchdog oscillator, nominally 400 kHz, is a selectable source
// - External mode frees crystal output pin for port or clock out
// - Clock output only when crystal oscillator is unused
// - Clock output pin driven only while enable bit is set; after a clear the code keeps it driven until the output level is low
// - Clock output toggles at half the core clock
// - Trim register: enable bit 6, trim bits 5..0, bit 7 unused
// - Core clock held off for oscillator count plus settle time
// - Divider reaches 510, changeable at any time
//
// The plain strobed port was decided locally.
`include "clock_unit_defs.svh"

module clock_source_and_output_unit #(
  parameter logic [6:0] FACTORY_TUNE = `RST_FACTORY_TUNE,
  parameter int         DIV_WIDTH    = 8
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic                       porRst_b,
  input  wire logic [2:0]                 sourceConfig,
  input  wire logic                       rtcUsesCrystal,
  input  wire logic                       wakeReq,
  input  wire logic                       stopReq,
  input  wire logic                       wdOscIn,
  input  wire logic                       rcOscIn,
  input  wire logic                       crystalInPin,
  input  wire logic                       portOut,
  input  wire logic                       portOe,
  output logic                            crystalOutPinOut,
  output logic                            crystalOutPinOe,
  input  wire logic [7:0]                 regAddr,
  input  wire logic [7:0]                 regWrData,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic [7:0]                      regRdData,
  output logic [5:0]                      rcTrim,
  output logic                            rcOscEnable,
  output logic                            xtalAmpEnable,
  output clock_unit_pkg::xtal_range_t     crystalRange,
  output logic                            coreClockTick,
  output logic                            peripheralClockTick,
  output logic                            machinePhase,
  output logic                            clockRunning
);
  import clock_unit_pkg::*;

  localparam logic [11:0] SETTLE_CYCLES = 12'(`WAKE_SETTLE_CYCLES);

  if (DIV_WIDTH < 1 || DIV_WIDTH > 8) begin : g_bad_width
    $error("DIV_WIDTH must be 1 to 8");
  end

  // ============================================================
  // Source configuration
  source_t source;
  wire     cfgLegal;
  wire     xtalSource;
  wire     clkOutAvail;

  assign cfgLegal = (sourceConfig <= SRC_EXTERNAL);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      source <= cfgLegal ? source_t'(sourceConfig) : SRC_RC;
    end
  end

  assign xtalSource = (source == SRC_XTAL_LOW) ||
                      (source == SRC_XTAL_MED) ||
                      (source == SRC_XTAL_HIGH);
  assign clkOutAvail = !xtalSource && !rtcUsesCrystal;

  always_comb begin
    unique case (source)
      SRC_XTAL_LOW:  crystalRange = RANGE_LOW;
      SRC_XTAL_MED:  crystalRange = RANGE_MED;
      SRC_XTAL_HIGH: crystalRange = RANGE_HIGH;
      default:       crystalRange = rtcUsesCrystal ? RANGE_LOW : RANGE_OFF;
    endcase
  end

  assign rcOscEnable   = (source == SRC_RC);
  assign xtalAmpEnable = xtalSource || rtcUsesCrystal;

  // ============================================================
  // Oscillator sampling
  // Edges are counted, so 18 MHz is near the limit of a 40 MHz sampler
  logic [2:0] oscMeta;
  logic [2:0] oscSync;
  logic       oscPrev;
  wire        oscSel;
  wire        oscTick;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      oscMeta <= 3'h0;
      oscSync <= 3'h0;
      oscPrev <= 1'b0;
    end else begin
      oscMeta <= {crystalInPin, rcOscIn, wdOscIn};
      oscSync <= oscMeta;
      oscPrev <= oscSel;
    end
  end

  // Crystal and external both on crystal input pin
  assign oscSel = (source == SRC_WATCHDOG) ? oscSync[0] :
                  (source == SRC_RC)       ? oscSync[1] : oscSync[2];
  assign oscTick = oscSel && !oscPrev;

  // ============================================================
  // Wake-up sequence
  wake_t       state;
  wake_t       next_state;
  logic [11:0] wakeCnt;
  wire  [11:0] oscLimit;
  wire         oscDone;
  wire         timeDone;

  assign oscLimit = xtalSource ? `XTAL_WAKE_OSC : `OTHER_WAKE_OSC;
  assign oscDone  = oscTick && (wakeCnt == oscLimit - 12'd1);
  assign timeDone = (wakeCnt == SETTLE_CYCLES - 12'd1);

  always_comb begin
    next_state = state;
    unique case (state)
      WAKE_OSC:  if (oscDone) next_state = WAKE_TIME;
      WAKE_TIME: if (timeDone) next_state = WAKE_RUN;
      WAKE_RUN:  if (stopReq) next_state = WAKE_STOP;
      WAKE_STOP: if (wakeReq) next_state = WAKE_OSC;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state   <= WAKE_OSC;
      wakeCnt <= 12'h000;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        wakeCnt <= 12'h000;
      end else if (state == WAKE_TIME || (state == WAKE_OSC && oscTick)) begin
        wakeCnt <= wakeCnt + 12'd1;
      end
    end
  end

  assign clockRunning = (state == WAKE_RUN);

  // ============================================================
  // Registers
  logic [6:0]           tune;
  logic [DIV_WIDTH-1:0] coreDiv;
  logic                 clkOutRun;
  wire                  hitTune;
  wire                  hitDiv;
  wire                  hitStat;
  wire  [7:0]           statusByte;
  wire  [7:0]           readMux;

  assign hitTune = (regAddr == `OFS_RC_TUNE);
  assign hitDiv  = (regAddr == `OFS_CORE_DIV);
  assign hitStat = (regAddr == `OFS_CLOCK_STATUS);

  // Power-on reset only; trim and enable fields
  always_ff @(posedge ref_clk) begin
    if (!porRst_b) begin
      tune <= FACTORY_TUNE;
    end else if (regWr && hitTune) begin
      tune <= regWrData[`TUNE_DIVIDED_CLOCK_OUTPUT_PIN_BIT:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      coreDiv <= DIV_WIDTH'(`RST_CORE_DIV);
    end else if (regWr && hitDiv) begin
      coreDiv <= regWrData[DIV_WIDTH-1:0];
    end
  end

  assign rcTrim = tune[`TUNE_TRIM_MSB:0];

  assign statusByte = {clockRunning, clkOutRun, clkOutAvail, 2'b00,
                       source};
  assign readMux = hitTune ? {1'b0, tune} :
                   hitDiv  ? 8'(coreDiv) :
                   hitStat ? statusByte : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regRd ? readMux : 8'h00;
    end
  end

  // ============================================================
  // Core and peripheral clock enables
  wire divTick;
  wire coreNow;

  core_clock_divider #(
    .DIV_WIDTH   (DIV_WIDTH)
  ) core_clock_divider_inst (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .oscTick     (oscTick),
    .divideValue (coreDiv),
    .divTick     (divTick)
  );

  // Core clock gated by wake state
  assign coreNow = divTick && clockRunning;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      coreClockTick       <= 1'b0;
      peripheralClockTick <= 1'b0;
      machinePhase        <= 1'b0;
    end else begin
      coreClockTick       <= coreNow;
      peripheralClockTick <= coreNow && machinePhase;
      if (coreNow) begin
        machinePhase <= !machinePhase;
      end
    end
  end

  // ============================================================
  // Clock output pin
  logic clkOutLevel;
  wire  clkOutWanted;

  assign clkOutWanted = tune[`TUNE_DIVIDED_CLOCK_OUTPUT_PIN_BIT] && clkOutAvail;

  // Start and stop at low level; loss of availability stops at once at any level
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      clkOutRun   <= 1'b0;
      clkOutLevel <= 1'b0;
    end else if (!clkOutAvail) begin
      clkOutRun   <= 1'b0;
      clkOutLevel <= 1'b0;
    end else begin
      if (!clkOutRun && clkOutWanted) begin
        clkOutRun <= 1'b1;
      end else if (clkOutRun && !clkOutWanted && !clkOutLevel) begin
        clkOutRun <= 1'b0;
      end
      // Half core rate
      // Never toggle up on the edge that stops the output
      if (clkOutRun && coreNow && (clkOutWanted || clkOutLevel)) begin
        clkOutLevel <= !clkOutLevel;
      end
    end
  end

  assign crystalOutPinOut = clkOutRun ? clkOutLevel : portOut;
  assign crystalOutPinOe  = clkOutRun ||
                            (source == SRC_EXTERNAL && portOe);

  // ============================================================
  // Assertions
  logic [1:0] coreSincePeriph;

  always_ff @(posedge ref_clk) begin
    if (!rst_b || peripheralClockTick) begin
      coreSincePeriph <= 2'd0;
    end else if (coreClockTick && coreSincePeriph != 2'd3) begin
      coreSincePeriph <= coreSincePeriph + 2'd1;
    end
  end

  sequence s_settle_end;
    state == WAKE_TIME && wakeCnt == SETTLE_CYCLES - 12'd1;
  endsequence

  sequence s_run_next;
    ##1 state == WAKE_RUN;
  endsequence

  property p_run_after_settle;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(state == WAKE_RUN) |-> $past(state == WAKE_TIME) &&
        $past(wakeCnt) == SETTLE_CYCLES - 12'd1;
  endproperty

  AST_SOURCE_FIXED: assert property (@(posedge ref_clk)
    disable iff (!rst_b) $stable(source))
    else $error("oscillator source changed outside reset");

  AST_CORE_HELD: assert property (@(posedge ref_clk)
    disable iff (!rst_b) !$past(clockRunning) |-> !coreClockTick)
    else $error("core clock ticked during wake-up hold");

  AST_SETTLE_RUN: assert property (@(posedge ref_clk)
    disable iff (!rst_b) s_settle_end |-> s_run_next)
    else $error("settle count did not end in run");

  AST_RUN_CAUSE: assert property (p_run_after_settle)
    else $error("run entered without full settle count");

  AST_PERIPH_HALF: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    peripheralClockTick |-> coreClockTick && coreSincePeriph == 2'd1)
    else $error("peripheral tick not on every second core tick");

  AST_MACHINE_PHASE: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    coreClockTick |-> machinePhase != $past(machinePhase))
    else $error("machine phase did not advance on core tick");

  AST_TRIM_KEPT: assert property (@(posedge ref_clk)
    (porRst_b && !rst_b) |=> $stable(tune))
    else $error("trim changed by a non power-on reset");

  AST_TRIM_FACTORY: assert property (@(posedge ref_clk)
    !porRst_b |=> tune == FACTORY_TUNE)
    else $error("power-on reset did not load factory trim");

  AST_DIVIDED_CLOCK_OUTPUT_PIN_AVAIL: assert property (@(posedge ref_clk)
    disable iff (!rst_b) clkOutRun |-> !xtalSource && !$past(rtcUsesCrystal))
    else $error("clock output while crystal in use");

  AST_DIVIDED_CLOCK_OUTPUT_PIN_START: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    $rose(clkOutRun) |-> !clkOutLevel && $past(tune[`TUNE_DIVIDED_CLOCK_OUTPUT_PIN_BIT]))
    else $error("clock output started without enable or at high level");

  AST_DIVIDED_CLOCK_OUTPUT_PIN_TOGGLE: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    $changed(clkOutLevel) && clkOutRun |-> coreClockTick)
    else $error("clock output toggled off a core tick");

endmodule

/* verif/osc_source_model.sv */
// Far-side oscillator model: watchdog, RC and crystal or external clock.
// Assumes the enables come from the unit or the bench; times in ns.
module osc_source_model #(
  parameter int WD_HALF   = 1250,
  parameter int RC_HALF   = 68,
  parameter int XTAL_HALF = 50
) (
  input  wire logic rcEnable,
  input  wire logic ampEnable,
  input  wire logic extRun,
  output logic      wdOsc,
  output logic      rcOsc,
  output logic      xtalPin
);
  timeunit 1ns;
  timeprecision 100ps;

  // ============================================================
  // Sources
  // free-running 400 kHz
  initial begin
    wdOsc = 1'b0;
    forever #(WD_HALF) wdOsc = ~wdOsc;
  end
  // near nominal rate, only while enabled
  initial begin
    rcOsc = 1'b0;
    forever #(RC_HALF) if (rcEnable) rcOsc = ~rcOsc;
  end
  // 10 MHz, below 12 MHz; stands still when stopped
  initial begin
    xtalPin = 1'b0;
    forever #(XTAL_HALF) if (ampEnable || extRun) xtalPin = ~xtalPin;
  end
endmodule

/* verif/clock_source_and_output_unit_test.sv */
// Self-checking bench of the clock source and output unit.
// Assumes the oscillator model on the far side and a 40 MHz ref_clk.
`include "clock_unit_defs.svh"
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errors++; \
  $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end

module clock_source_and_output_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  import clock_unit_pkg::*;

  localparam logic [6:0] FT     = 7'h20;
  localparam int         RC_PER = 136;
  localparam int         XT_PER = 100;
  logic        ref_clk = 1'b0, rst_b = 1'b0, porRst_b = 1'b0;
  logic [2:0]  sourceConfig = 3'd1;
  logic        rtcUsesCrystal = 1'b0, wakeReq = 1'b0, stopReq = 1'b0;
  logic        portOut = 1'b0, portOe = 1'b0, extRun = 1'b0;
  logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData, rd;
  logic        regWr = 1'b0, regRd = 1'b0;
  logic        wdOscIn, rcOscIn, crystalInPin;
  logic        crystalOutPinOut, crystalOutPinOe;
  logic [5:0]  rcTrim;
  logic        rcOscEnable, xtalAmpEnable, coreClockTick;
  logic        peripheralClockTick, machinePhase, clockRunning;
  logic        ph = 1'b0, oo = 1'b0, lastOut = 1'b0;
  xtal_range_t crystalRange;
  int          errors = 0, nChecks = 0, cyc = 0;
  int          core = 0, per = 0, phr = 0, orise = 0;
  int          dv[3] = '{0, 2, 255};
  logic [31:0] seed = 32'h5684;

  clock_source_and_output_unit #(.FACTORY_TUNE(FT))
    clock_source_and_output_unit_inst (
    .ref_clk, .rst_b, .porRst_b, .sourceConfig, .rtcUsesCrystal,
    .wakeReq, .stopReq, .wdOscIn, .rcOscIn, .crystalInPin, .portOut,
    .portOe, .crystalOutPinOut, .crystalOutPinOe, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .rcTrim, .rcOscEnable, .xtalAmpEnable,
    .crystalRange, .coreClockTick, .peripheralClockTick, .machinePhase,
    .clockRunning);

  osc_source_model osc_source_model_inst (
    .rcEnable(rcOscEnable), .ampEnable(xtalAmpEnable), .extRun(extRun),
    .wdOsc(wdOscIn), .rcOsc(rcOscIn), .xtalPin(crystalInPin));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ============================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic xtal_range_t expRange(input logic [2:0] s);
    case (s)
      3'd2: return RANGE_LOW;
      3'd3: return RANGE_MED;
      3'd4: return RANGE_HIGH;
      default: return rtcUsesCrystal ? RANGE_LOW : RANGE_OFF;
    endcase
  endfunction

  function automatic int wakeLo(input int edges, input int pns);
    return edges * pns / 25 + `WAKE_SETTLE_CYCLES;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic rdReg(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 rd = regRdData;
  endtask

  task automatic boot(input logic [2:0] s, input logic por);
    @(posedge ref_clk);
    sourceConfig <= s;
    rst_b <= 1'b0;
    porRst_b <= ~por;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    porRst_b <= 1'b1;
    #1;
  endtask

  // Slack covers the 60 to 100 us settle spread
  task automatic waitRun(input int lo);
    int n;
    n = 0;
    while (clockRunning !== 1'b1 && n < lo + 1700) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(n >= lo - 20 && n < lo + 1700, 1'b1)
  endtask

  task automatic clrCnt();
    core = 0;
    per = 0;
    phr = 0;
    orise = 0;
  endtask

  task automatic wrap_up();
    $display("Checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ============================================================
  // Monitor and timeout
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      wrap_up();
    end
    core += coreClockTick;
    per += peripheralClockTick;
    if (machinePhase && !ph) phr++;
    if (crystalOutPinOut && !oo && crystalOutPinOe) orise++;
    if (crystalOutPinOe) lastOut = crystalOutPinOut;
    ph = machinePhase;
    oo = crystalOutPinOut;
    if (rst_b) `CHK(peripheralClockTick && !coreClockTick, 1'b0)
  end

  // ============================================================
  // Scenarios
  initial begin
    int d;
    int m;
    boot(SRC_RC, 1'b1);
    rdReg(`OFS_RC_TUNE);
    `CHK(rd, {1'b0, FT})
    rdReg(`OFS_CLOCK_STATUS);
    `CHK(rd[2:0], SRC_RC)
    rdReg(8'h55);
    `CHK(rd, 8'h00)
    `CHK({rcOscEnable, xtalAmpEnable}, 2'b10)
    waitRun(wakeLo(224, RC_PER));
    for (m = 0; m < 10; m++) begin
      d = (m == 0) ? 32'hFF : (m == 1) ? 32'h00 : xs();
      wr(`OFS_RC_TUNE, d[7:0]);
      `CHK(rcTrim, d[5:0])
      rdReg(`OFS_RC_TUNE);
      `CHK(rd, d[7:0] & 8'h7F)
    end
    foreach (dv[i]) begin
      wr(`OFS_CORE_DIV, dv[i][7:0]);
      repeat (20) @(posedge ref_clk);
      clrCnt();
      repeat (2000) @(posedge ref_clk);
      d = 50000 / (RC_PER * (dv[i] == 0 ? 1 : 2 * dv[i]));
      `CHK(core >= d - 3 && core <= d + 3, 1'b1)
      `CHK(per >= core / 2 - 1 && per <= core / 2 + 1, 1'b1)
      `CHK(phr >= core / 2 - 1 && phr <= core / 2 + 1, 1'b1)
    end
    wr(`OFS_CORE_DIV, 8'h00);
    wr(`OFS_RC_TUNE, 8'h45);
    repeat (2) @(posedge ref_clk);
    #1 `CHK(crystalOutPinOe, 1'b1)
    clrCnt();
    repeat (2000) @(posedge ref_clk);
    `CHK(orise >= core / 2 - 1 && orise <= core / 2 + 1, 1'b1)
    wr(`OFS_RC_TUNE, 8'h05);
    m = 0;
    while (crystalOutPinOe !== 1'b0 && m < 20) begin
      @(posedge ref_clk);
      m++;
    end
    `CHK(crystalOutPinOe, 1'b0)
    `CHK(lastOut, 1'b0)
    @(posedge ref_clk);
    rtcUsesCrystal <= 1'b1;
    wr(`OFS_RC_TUNE, 8'h45);
    repeat (3) @(posedge ref_clk);
    #1 `CHK({crystalOutPinOe, xtalAmpEnable}, 2'b01)
    `CHK(crystalRange, RANGE_LOW)
    @(posedge ref_clk);
    rtcUsesCrystal <= 1'b0;
    boot(SRC_XTAL_HIGH, 1'b0);
    rdReg(`OFS_RC_TUNE);
    `CHK(rd, 8'h45)
    `CHK(crystalOutPinOe, 1'b0)
    waitRun(wakeLo(992, XT_PER));
    for (m = 0; m < 6; m++) begin
      boot(m[2:0], 1'b0);
      `CHK(rcOscEnable, m == 1)
      `CHK(xtalAmpEnable, m >= 2 && m <= 4)
      `CHK(crystalRange, expRange(m[2:0]))
      rdReg(`OFS_CLOCK_STATUS);
      `CHK(rd[2:0], m[2:0])
    end
    extRun <= 1'b1;
    waitRun(wakeLo(224, XT_PER));
    repeat (4) @(posedge ref_clk);
    `CHK(crystalOutPinOe, 1'b1)
    wr(`OFS_RC_TUNE, 8'h05);
    @(posedge ref_clk);
    portOe <= 1'b1;
    repeat (8) begin
      d = xs();
      @(posedge ref_clk);
      portOut <= d[0];
      repeat (20) @(posedge ref_clk);
      #1 `CHK({crystalOutPinOe, crystalOutPinOut}, {1'b1, d[0]})
    end
    // Static external clock must simply freeze the core
    extRun <= 1'b0;
    repeat (10) @(posedge ref_clk);
    clrCnt();
    repeat (300) @(posedge ref_clk);
    `CHK(core, 0)
    extRun <= 1'b1;
    @(posedge ref_clk);
    stopReq <= 1'b1;
    @(posedge ref_clk);
    stopReq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 `CHK(clockRunning, 1'b0)
    clrCnt();
    @(posedge ref_clk);
    wakeReq <= 1'b1;
    @(posedge ref_clk);
    wakeReq <= 1'b0;
    waitRun(wakeLo(224, XT_PER));
    `CHK(core < 3, 1'b1)
    wrap_up();
  end
endmodule
